//--- design/bcal_capacity_learn.v
`include "bcal_defines.vh"

module bcal_capacity_learn #(
  parameter VOLT_SHIFT = 0
) (
  // Clock and reset
  input  wire               sys_clk,
  input  wire               reset_n,
  // Register port
  input  wire [7:0]         reg_addr,
  input  wire [7:0]         reg_wdata,
  input  wire               reg_write,
  input  wire               reg_read,
  output reg  [7:0]         reg_rdata,
  // Measurement results, one-cycle strobe per interval
  input  wire               meas_valid,
  input  wire [7:0]         cell_sense_voltage,
  input  wire signed [15:0] current_result,
  input  wire signed [15:0] averaged_current,
  input  wire               count_step,
  input  wire               count_decreasing,
  input  wire [7:0]         active_relative_remaining,
  input  wire [7:0]         standby_relative_remaining,
  // Cell model values at present temperature
  input  wire [15:0]        model_full_value,
  input  wire [15:0]        model_active_empty,
  // Nonvolatile age scalar and sleep
  input  wire [7:0]         stored_age_scalar,
  input  wire               sleep_enter,
  output reg                age_store_req,
  output reg  [7:0]         age_store_data,
  // State outputs
  output reg  [15:0]        coulomb_count,
  output reg  [7:0]         age_scalar
);

  reg [15:0] rated_cell_charge;
  reg [7:0]  full_voltage_threshold;
  reg [7:0]  taper_current_threshold;
  reg [7:0]  active_floor_voltage;
  reg [7:0]  active_floor_current;
  reg [7:0]  undervoltage_threshold;
  reg        full_charge_flag;
  reg        active_floor_flag;
  reg        standby_floor_flag;
  reg        learn_window_flag;
  reg        low_voltage_flag;
  reg        power_up_flag;
  reg [20:0] discharge_count;
  reg [23:0] learned_charge;
  reg        boot_load;
  reg        prev_chg_ok;
  reg        prev_dis_ok;
  reg        prev2_dis_ok;

  // Age scalar saturating at the floor code
  function [7:0] age_clamp;
    input [8:0] val;
    begin
      if (val < {1'b0, `BCAL_AGE_FLOOR})
        age_clamp = `BCAL_AGE_FLOOR;
      else if (val > 9'h0ff)
        age_clamp = 8'hff;
      else
        age_clamp = val[7:0];
    end
  endfunction

  // Aging step: a value already at or under the floor must not wrap upward
  function [7:0] age_dec;
    input [7:0] val;
    begin
      if (val <= `BCAL_AGE_FLOOR)
        age_dec = `BCAL_AGE_FLOOR;
      else
        age_dec = val - 8'h01;
    end
  endfunction

  // Status byte layout; reserved bits read as zero
  function [7:0] status_byte;
    input full, afloor, sfloor, learn, lowv, pwrup;
    begin
      status_byte = {full, afloor, sfloor, learn, 1'b0, lowv, pwrup, 1'b0};
    end
  endfunction

  // Floor and undervoltage settings share the result's 19.5 mV scale; full setting sees it shifted by VOLT_SHIFT
  wire volt_high = (cell_sense_voltage >> VOLT_SHIFT) > full_voltage_threshold;
  wire volt_low  = cell_sense_voltage < active_floor_voltage;
  wire uv_now    = cell_sense_voltage < undervoltage_threshold;
  // Averaged current in 50 uV units compared against the taper setting
  wire chg_ok = (averaged_current > `BCAL_MIN_CHG_LSB) &&
                (averaged_current < $signed({8'h00, taper_current_threshold}));
  wire dis_ok = (current_result < 16'sh0000) &&
                ((-current_result) > $signed({8'h00, active_floor_current}));
  wire full_det  = meas_valid && volt_high && chg_ok && prev_chg_ok;
  wire empty_det = meas_valid && volt_low && prev_dis_ok && prev2_dis_ok;

  wire [20:0] age_limit = {rated_cell_charge, 5'h00};
  wire        age_tick  = count_step && count_decreasing &&
                          (discharge_count + 21'd1 >= age_limit) &&
                          (rated_cell_charge != `BCAL_RST_RATED);

  // Learned scalar: charge since empty over full span, 2^-7 steps
  wire [31:0] learn_quot = (model_full_value == 16'h0000) ? 32'h0 :
              ({learned_charge, 7'h00} / {8'h00, model_full_value});
  wire [8:0]  learn_age  = (learn_quot > 32'h0ff) ? 9'h0ff : learn_quot[8:0];
  wire [7:0]  next_age_learn = age_clamp(learn_age);
  // Count value after full uses the updated scalar
  wire [7:0]  age_for_full = (full_det && learn_window_flag) ?
                             next_age_learn : age_scalar;
  wire [23:0] scaled_full = ({8'h00, model_full_value} * {16'h0, age_for_full})
                            >> 7;

  wire wr_status = reg_write && (reg_addr == `BCAL_ADDR_STATUS);
  wire wr_count  = reg_write && ((reg_addr == `BCAL_ADDR_COUNT_HI) ||
                                 (reg_addr == `BCAL_ADDR_COUNT_LO));

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      age_scalar     <= `BCAL_AGE_UNAGED;
      coulomb_count  <= 16'h0000;
      age_store_req  <= 1'b0;
      age_store_data <= `BCAL_AGE_UNAGED;
    end else begin
      age_store_req <= 1'b0;
      // Stored scalar caught one edge after release, not under reset
      if (boot_load)
        age_scalar <= age_clamp({1'b0, stored_age_scalar});

      // Aging decrement, saved in the same cycle
      if (age_tick) begin
        age_scalar     <= age_dec(age_scalar);
        age_store_req  <= 1'b1;
        age_store_data <= age_dec(age_scalar);
      end

      // Coulomb count housekeeping, full beats empty
      if (count_step)
        coulomb_count <= count_decreasing ?
          ((coulomb_count == 16'h0) ? 16'h0 : coulomb_count - 16'd1) :
          coulomb_count + 16'd1;
      if (full_det) begin
        coulomb_count <= scaled_full[15:0];
        if (learn_window_flag) begin
          age_scalar     <= next_age_learn;
          age_store_req  <= 1'b1;
          age_store_data <= next_age_learn;
        end
      end else if (empty_det) begin
        coulomb_count <= model_active_empty;
      end else if (meas_valid && active_floor_flag && !learn_window_flag &&
                   coulomb_count > model_active_empty) begin
        coulomb_count <= model_active_empty;
      end else if (reg_write && reg_addr == `BCAL_ADDR_COUNT_HI) begin
        coulomb_count[15:8] <= reg_wdata;
      end else if (reg_write && reg_addr == `BCAL_ADDR_COUNT_LO) begin
        coulomb_count[7:0] <= reg_wdata;
      end

      // Host age write is taken verbatim; software owns that risk
      if (reg_write && reg_addr == `BCAL_ADDR_AGE) begin
        age_scalar     <= reg_wdata;
        age_store_req  <= 1'b1;
        age_store_data <= reg_wdata;
      end
    end
  end

  // One-shot marker for the reload edge after reset release
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      boot_load <= 1'b1;
    else
      boot_load <= 1'b0;
  end

  // Qualifier history, advanced only on measurement strobes
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_chg_ok  <= 1'b0;
      prev_dis_ok  <= 1'b0;
      prev2_dis_ok <= 1'b0;
    end else if (meas_valid) begin
      prev_chg_ok  <= chg_ok && volt_high;
      prev_dis_ok  <= dis_ok;
      prev2_dis_ok <= prev_dis_ok;
    end
  end

  // Aging interval counter, restarted by each decrement
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      discharge_count <= 21'h0;
    else if (count_step && count_decreasing) begin
      if (age_tick)
        discharge_count <= 21'h0;
      else
        discharge_count <= discharge_count + 21'd1;
    end
  end

  // Charge gathered since the empty point; restarts at each empty point
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      learned_charge <= 24'h0;
    else if (empty_det)
      learned_charge <= 24'h0;
    else if (learn_window_flag && count_step && !count_decreasing)
      learned_charge <= learned_charge + 24'd1;
  end

  // Settings registers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rated_cell_charge       <= `BCAL_RST_RATED;
      full_voltage_threshold  <= `BCAL_RST_BYTE;
      taper_current_threshold <= `BCAL_RST_BYTE;
      active_floor_voltage    <= `BCAL_RST_BYTE;
      active_floor_current    <= `BCAL_RST_BYTE;
      undervoltage_threshold  <= `BCAL_RST_BYTE;
    end else if (reg_write) begin
      case (reg_addr)
        `BCAL_ADDR_RATED_HI: rated_cell_charge[15:8] <= reg_wdata;
        `BCAL_ADDR_RATED_LO: rated_cell_charge[7:0]  <= reg_wdata;
        `BCAL_ADDR_FULLV:    full_voltage_threshold  <= reg_wdata;
        `BCAL_ADDR_TAPER:    taper_current_threshold <= reg_wdata;
        `BCAL_ADDR_FLOORV:   active_floor_voltage    <= reg_wdata;
        `BCAL_ADDR_FLOORI:   active_floor_current    <= reg_wdata;
        `BCAL_ADDR_UVTH:     undervoltage_threshold  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Full flag; a new full detection beats the percentage clear
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      full_charge_flag <= 1'b0;
    else if (full_det)
      full_charge_flag <= 1'b1;
    else if (meas_valid && active_relative_remaining < `BCAL_PCT_FULL_CLR)
      full_charge_flag <= 1'b0;
  end

  // Active-floor flag; clear is checked every cycle, set wins
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      active_floor_flag <= 1'b0;
    else if (meas_valid && volt_low)
      active_floor_flag <= 1'b1;
    else if (active_relative_remaining > `BCAL_PCT_AFLOOR_CLR)
      active_floor_flag <= 1'b0;
  end

  // Standby-floor flag; the gap between levels gives hysteresis
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      standby_floor_flag <= 1'b0;
    else if (standby_relative_remaining > `BCAL_PCT_SFLOOR_CLR)
      standby_floor_flag <= 1'b0;
    else if (standby_relative_remaining < `BCAL_PCT_SFLOOR_SET)
      standby_floor_flag <= 1'b1;
  end

  // Learn window; a new empty point beats the clearing events
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      learn_window_flag <= 1'b0;
    else if (empty_det)
      learn_window_flag <= 1'b1;
    else if (full_det || sleep_enter || wr_count ||
             current_result < 16'sh0000 || coulomb_count == 16'h0)
      learn_window_flag <= 1'b0;
  end

  // Low-voltage flag; a persisting undervoltage overrides the host clear
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      low_voltage_flag <= 1'b1;
    else if (uv_now)
      low_voltage_flag <= 1'b1;
    else if (wr_status && !reg_wdata[`BCAL_BIT_LOWV])
      low_voltage_flag <= 1'b0;
  end

  // Power-up flag, cleared only by software
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      power_up_flag <= 1'b1;
    else if (wr_status && !reg_wdata[`BCAL_BIT_PWRUP])
      power_up_flag <= 1'b0;
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `BCAL_ADDR_STATUS: reg_rdata <= status_byte(full_charge_flag,
          active_floor_flag, standby_floor_flag, learn_window_flag,
          low_voltage_flag, power_up_flag);
        `BCAL_ADDR_AGE:      reg_rdata <= age_scalar;
        `BCAL_ADDR_RATED_HI: reg_rdata <= rated_cell_charge[15:8];
        `BCAL_ADDR_RATED_LO: reg_rdata <= rated_cell_charge[7:0];
        `BCAL_ADDR_FULLV:    reg_rdata <= full_voltage_threshold;
        `BCAL_ADDR_TAPER:    reg_rdata <= taper_current_threshold;
        `BCAL_ADDR_FLOORV:   reg_rdata <= active_floor_voltage;
        `BCAL_ADDR_FLOORI:   reg_rdata <= active_floor_current;
        `BCAL_ADDR_UVTH:     reg_rdata <= undervoltage_threshold;
        `BCAL_ADDR_COUNT_HI: reg_rdata <= coulomb_count[15:8];
        `BCAL_ADDR_COUNT_LO: reg_rdata <= coulomb_count[7:0];
        default:             reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // bcal_capacity_learn

//--- design/bcal_defines.vh
`ifndef BCAL_DEFINES_VH
`define BCAL_DEFINES_VH
// Register map, plain 8-bit port
`define BCAL_ADDR_STATUS     8'h01
`define BCAL_ADDR_AGE        8'h02
`define BCAL_ADDR_RATED_HI   8'h03
`define BCAL_ADDR_RATED_LO   8'h04
`define BCAL_ADDR_FULLV      8'h05
`define BCAL_ADDR_TAPER      8'h06
`define BCAL_ADDR_FLOORV     8'h07
`define BCAL_ADDR_FLOORI     8'h08
`define BCAL_ADDR_UVTH       8'h09
`define BCAL_ADDR_COUNT_HI   8'h0a
`define BCAL_ADDR_COUNT_LO   8'h0b
// Status bit positions
`define BCAL_BIT_FULL        7
`define BCAL_BIT_AFLOOR      6
`define BCAL_BIT_SFLOOR      5
`define BCAL_BIT_LEARN       4
`define BCAL_BIT_LOWV        2
`define BCAL_BIT_PWRUP       1
// Age scalar codes
`define BCAL_AGE_UNAGED      8'h80
`define BCAL_AGE_FLOOR       8'h40
// Aging interval multiplier
`define BCAL_AGE_MULT_SHIFT  5
// Relative capacity thresholds in percent
`define BCAL_PCT_FULL_CLR    8'h5a
`define BCAL_PCT_AFLOOR_CLR  8'h05
`define BCAL_PCT_SFLOOR_SET  8'h0a
`define BCAL_PCT_SFLOOR_CLR  8'h0f
// Averaged current must exceed this for full detection
`define BCAL_MIN_CHG_LSB     16'sh0010
// Reset values of settings
`define BCAL_RST_RATED       16'h0000
`define BCAL_RST_BYTE        8'h00
`endif

//--- bench/bcal_chk_assertions.sv
module bcal_chk (
  // Clock and register port
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  // Events and state
  input wire logic        meas_valid,
  input wire logic        count_step,
  input wire logic [7:0]  stored_age_scalar,
  input wire logic        age_store_req,
  input wire logic [7:0]  age_store_data,
  input wire logic [15:0] coulomb_count,
  input wire logic [7:0]  age_scalar
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Learning lands on the strobe edge; the following edge is excluded as well
  sequence s_quiet;
    $past(reset_n, 2) && !$past(reg_write) && !$past(meas_valid) &&
      !$past(meas_valid, 2);
  endsequence
  sequence s_saved;
    ##[0:2] (age_store_req && age_store_data == age_scalar);
  endsequence
  chk_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_rsvd_bits: assert property ($past(reg_read && reg_addr == 8'h01)
    |-> reg_rdata[3] == 1'b0 && reg_rdata[0] == 1'b0)
    else $error("reserved status bits read non zero");
  chk_unmapped_zero: assert property
    ($past(reg_read && (reg_addr == 8'h00 || reg_addr > 8'h0b))
    |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_age_reload: assert property (!$past(reset_n) |=>
    age_scalar == ($past(stored_age_scalar) < 8'h40 ? 8'h40
                   : $past(stored_age_scalar)))
    else $error("age scalar not reloaded from storage");
  chk_age_floor: assert property ($past(reset_n, 2) &&
    !$past(reg_write && reg_addr == 8'h02) &&
    age_scalar < $past(age_scalar) |-> age_scalar >= 8'h40)
    else $error("age scalar fell below floor");
  chk_age_step: assert property (s_quiet ##0
    (age_scalar < $past(age_scalar)) |-> age_scalar == $past(age_scalar) - 8'h01)
    else $error("aging decrement not one code");
  chk_age_saved: assert property ($past(reset_n, 2) &&
    $changed(age_scalar) |-> s_saved)
    else $error("age scalar change not saved");
  chk_count_lo: assert property
    ($past(reg_write && reg_addr == 8'h0b && !meas_valid && !count_step)
    |-> coulomb_count[7:0] == $past(reg_wdata))
    else $error("count low byte write lost");
endmodule // bcal_chk

bind bcal_capacity_learn bcal_chk i_bcal_chk (.sys_clk, .reset_n, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .meas_valid, .count_step,
  .stored_age_scalar, .age_store_req, .age_store_data, .coulomb_count,
  .age_scalar);

//--- bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               sys_clk = 1'b0, reset_n = 1'b0;
  logic [7:0]         reg_addr = 8'h00, reg_wdata = 8'h00;
  logic               reg_write = 1'b0, reg_read = 1'b0, meas_valid = 1'b0;
  logic [7:0]         volt = 8'h00, arr = 8'h00, srr = 8'h32;
  logic signed [15:0] cur = 16'sh0000, avg = 16'sh0000;
  logic               count_step = 1'b0, count_dec = 1'b0, sleep_enter = 1'b0;
  logic [7:0]         reg_rdata, age_scalar;
  logic [15:0]        coulomb_count;
  int                 bad_count = 0, check_count = 0;

  bcal_capacity_learn i_bcal_capacity_learn (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .cell_sense_voltage(volt), .current_result(cur),
    .averaged_current(avg), .count_step(count_step),
    .count_decreasing(count_dec), .active_relative_remaining(arr),
    .standby_relative_remaining(srr), .model_full_value(16'h0400),
    .model_active_empty(16'h0200), .stored_age_scalar(8'h30),
    .sleep_enter(sleep_enter), .age_store_req(), .age_store_data(),
    .coulomb_count(coulomb_count), .age_scalar(age_scalar));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  // Masked compare, so flags outside the scenario do not matter
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 cmp({8'h00, reg_rdata & m}, {8'h00, e});
    // Return on a rising edge so callers drive inputs there
    @(posedge sys_clk);
  endtask
  task automatic meas(input logic [7:0] v, input logic signed [15:0] c, a);
    @(posedge sys_clk);
    meas_valid <= 1'b1;
    volt <= v;
    cur  <= c;
    avg  <= a;
    @(posedge sys_clk);
    meas_valid <= 1'b0;
  endtask
  task automatic steps(input int n, input logic d);
    @(posedge sys_clk);
    count_step <= 1'b1;
    count_dec  <= d;
    repeat (n) @(posedge sys_clk);
    count_step <= 1'b0;
  endtask
  // Empty reading carries zero current: a discharge would clear learning
  task automatic empty_pt();
    meas(8'hc0, -16'sd2000, 16'sh0000);
    meas(8'hc0, -16'sd2000, 16'sh0000);
    meas(8'h80, 16'sh0000, 16'sh0000);
  endtask
  task automatic sb(input logic [7:0] p, input logic [7:0] e);
    srr <= p;
    meas(8'hc0, 16'sh0000, 16'sh0000);
    rd(8'h01, 8'h20, e);
  endtask
  task automatic complete_run();
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cmp({8'h00, age_scalar}, 16'h0040);
    rd(8'h01, 8'hff, 8'h06);
    wr(8'h01, 8'hf0);
    rd(8'h01, 8'hff, 8'h00);
    rd(8'h20, 8'hff, 8'h00);
    wr(8'h09, 8'h80);
    meas(8'h70, 16'sh0000, 16'sh0000);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h06, 8'h04);
    meas(8'hc0, 16'sh0000, 16'sh0000);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h06, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h01);
    wr(8'h0a, 8'h10);
    wr(8'h0b, 8'h00);
    wr(8'h02, 8'h79);
    rd(8'h02, 8'hff, 8'h79);
    steps(31, 1'b1);
    rd(8'h02, 8'hff, 8'h79);
    steps(1, 1'b1);
    rd(8'h02, 8'hff, 8'h78);
    steps(32, 1'b1);
    rd(8'h02, 8'hff, 8'h77);
    wr(8'h02, 8'h41);
    steps(64, 1'b1);
    rd(8'h02, 8'hff, 8'h40);
    wr(8'h05, 8'hd0);
    wr(8'h06, 8'h40);
    wr(8'h07, 8'h90);
    wr(8'h08, 8'h10);
    arr <= 8'h03;
    empty_pt();
    rd(8'h01, 8'hf0, 8'h50);
    cmp(coulomb_count, 16'h0200);
    steps(768, 1'b0);
    arr <= 8'h5f;
    meas(8'he0, 16'sd100, 16'sd16);
    meas(8'he0, 16'sd100, 16'sd32);
    rd(8'h01, 8'hf0, 8'h10);
    meas(8'he0, 16'sd100, 16'sd32);
    rd(8'h01, 8'hf0, 8'h80);
    cmp({8'h00, age_scalar}, 16'h0060);
    cmp(coulomb_count, 16'h0300);
    arr <= 8'h5a;
    meas(8'hc0, 16'sh0000, 16'sh0000);
    rd(8'h01, 8'h80, 8'h80);
    arr <= 8'h59;
    meas(8'hc0, 16'sh0000, 16'sh0000);
    rd(8'h01, 8'h80, 8'h00);
    sb(8'h0a, 8'h00);
    sb(8'h09, 8'h20);
    sb(8'h0f, 8'h20);
    sb(8'h10, 8'h00);
    arr <= 8'h03;
    wr(8'h0a, 8'h07);
    // Flag sets on this reading; the count is pulled in on the next one
    meas(8'h80, 16'sh0000, 16'sh0000);
    meas(8'h80, 16'sh0000, 16'sh0000);
    rd(8'h01, 8'h50, 8'h40);
    cmp(coulomb_count, 16'h0200);
    wr(8'h0a, 8'h01);
    meas(8'h80, 16'sh0000, 16'sh0000);
    rd(8'h01, 8'h50, 8'h40);
    cmp(coulomb_count, 16'h0100);
    empty_pt();
    rd(8'h01, 8'h10, 8'h10);
    @(posedge sys_clk);
    sleep_enter <= 1'b1;
    @(posedge sys_clk);
    sleep_enter <= 1'b0;
    rd(8'h01, 8'h10, 8'h00);
    empty_pt();
    meas(8'hc0, -16'sd5, 16'sh0000);
    rd(8'h01, 8'h10, 8'h00);
    empty_pt();
    wr(8'h0b, 8'h55);
    rd(8'h01, 8'h10, 8'h00);
    complete_run();
  end
endmodule // testbench
